// file: rtl/cmd_decoder.sv
`timescale 1ns/1ps
// Turns the registered command pins into a one-hot view of the command
module cmd_decoder (
   input wire sdram_spacing_pkg::cmd_bus_t bus,
   output logic is_activate,
   output logic is_read,
   output logic is_write,
   output logic is_stop,
   output logic is_precharge,
   output logic is_refresh,
   output logic is_mode_load
);
   logic [3:0] code;

   always_comb begin
      code = {bus.cs_b, bus.ras_b, bus.cas_b, bus.we_b};
      is_activate = code == sdram_spacing_pkg::CMD_ACTIVATE;
      is_read = code == sdram_spacing_pkg::CMD_READ;
      is_write = code == sdram_spacing_pkg::CMD_WRITE;
      is_stop = code == sdram_spacing_pkg::CMD_STOP;
      is_precharge = code == sdram_spacing_pkg::CMD_PRECHARGE;
      is_refresh = code == sdram_spacing_pkg::CMD_REFRESH;
      is_mode_load = code == sdram_spacing_pkg::CMD_MODE_LOAD;
   end
endmodule // cmd_decoder

// file: rtl/sdram_command_spacing.sv
`timescale 1ns/1ps
module sdram_command_spacing #(
   parameter int unsigned DATA_W = sdram_spacing_pkg::DATA_WIDTH,
   parameter int unsigned POWER_UP_CYCLES = sdram_spacing_pkg::POWER_UP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cke,
   input wire sdram_spacing_pkg::cmd_bus_t cmd,
   input wire logic dqm,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic [DATA_W-1:0] read_data,
   output sdram_spacing_pkg::write_beat_t wr_beat,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_b,
   output logic suspended,
   output logic ready,
   output logic read_latency3
);
   initial begin
      // The pause counter is 16 bits wide
      if (DATA_W != sdram_spacing_pkg::DATA_WIDTH || POWER_UP_CYCLES < 1
          || POWER_UP_CYCLES > 65536)
         $error("Unsupported parameter values");
   end

   localparam int unsigned RL = sdram_spacing_pkg::READ_LATENCY_MAX;

   typedef enum logic [2:0] {
      ST_PAUSE = 3'h1,
      ST_WAKE = 3'h2,
      ST_RUN = 3'h4
   } init_state_t;

   logic is_act, is_rd, is_wr, is_stop, is_pre, is_ref, is_mrs;
   logic cke_q, active_q, cmd_ok;
   logic [15:0] pause_q;
   logic [1:0] ref_cnt_q;
   init_state_t init_q;
   logic [RL:0] rd_pipe_q;
   logic [RL:0] mask_pipe_q;
   logic [RL-1:0] burst_q;

   cmd_decoder u_dec (
      .bus(cmd),
      .is_activate(is_act),
      .is_read(is_rd),
      .is_write(is_wr),
      .is_stop(is_stop),
      .is_precharge(is_pre),
      .is_refresh(is_ref),
      .is_mode_load(is_mrs)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock enable: commands registered only while the previous edge saw it
   always_ff @(posedge clk) begin
      if (!rst_b) cke_q <= 1'b1;
      else cke_q <= cke;
   end
   assign suspended = !cke_q;
   assign active_q = cke_q;
   assign cmd_ok = active_q && ready;

   ////////////////////////////////////////////////////////////////////////
   // Power-up wake sequence; WAKE_REFRESH_COUNT refreshes after the pause give ready
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         init_q <= ST_PAUSE;
         pause_q <= 16'h0000;
         ref_cnt_q <= 2'h0;
      end else begin
         unique case (init_q)
            ST_PAUSE: begin
               if (pause_q == 16'(POWER_UP_CYCLES - 1)) init_q <= ST_WAKE;
               else pause_q <= pause_q + 16'h0001;
            end
            ST_WAKE: begin
               if (active_q && is_ref) begin
                  ref_cnt_q <= ref_cnt_q + 2'h1;
                  if (ref_cnt_q == 2'(sdram_spacing_pkg::WAKE_REFRESH_COUNT - 1))
                     init_q <= ST_RUN;
               end
            end
            ST_RUN: init_q <= ST_RUN;
         endcase
      end
   end
   assign ready = init_q == ST_RUN;

   ////////////////////////////////////////////////////////////////////////
   // Mode register: bit 4 of the op-code picks read latency 3 over 2
   always_ff @(posedge clk) begin
      if (!rst_b) read_latency3 <= 1'b1;
      else if (cmd_ok && is_mrs) read_latency3 <= cmd.addr[4];
   end

   ////////////////////////////////////////////////////////////////////////
   // Write capture: data taken on the command edge, masked with no delay
   always_ff @(posedge clk) begin
      if (!rst_b) wr_beat <= '0;
      else begin
         wr_beat.valid <= cmd_ok && is_wr && !dqm;
         wr_beat.bank <= cmd.bank;
         wr_beat.addr <= cmd.addr;
         wr_beat.data <= dq_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read output: mask pipe four deep, tapped two back; precharge cuts burst after latency
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_pipe_q <= '0;
         mask_pipe_q <= '0;
         burst_q <= '0;
      end else begin
         mask_pipe_q <= {mask_pipe_q[RL-1:0], dqm};
         burst_q <= {burst_q[RL-2:0],
                     cmd_ok && (is_rd || (burst_q[0] && !is_pre
                                && !is_stop && !is_wr))};
         rd_pipe_q <= {rd_pipe_q[RL-1:0], cmd_ok && is_rd};
      end
   end

   logic drive;
   always_comb begin
      // Burst stays live until a precharge, stop, write or suspended cycle; delay by the read latency
      drive = read_latency3 ? burst_q[RL-1] : burst_q[RL-2];
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dq_oe_b <= 1'b1;
         dq_out <= '0;
      end else begin
         // Mask seen two edges back floats the word launched now
         dq_oe_b <= !(drive && !mask_pipe_q[
            sdram_spacing_pkg::READ_MASK_HIZ_LATENCY - 1]);
         dq_out <= read_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_mask_write_now: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_ok && is_wr && dqm |=> !wr_beat.valid)
      else $error("Masked write data was stored");
   chk_write_same_edge: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_ok && is_wr && !dqm |=> wr_beat.valid
         && wr_beat.data == $past(dq_in))
      else $error("Write data not taken with command");
   chk_suspend_entry: assert property (@(posedge clk) disable iff (!rst_b)
      !cke |=> suspended)
      else $error("Suspend not entered");
   chk_suspend_exit: assert property (@(posedge clk) disable iff (!rst_b)
      cke |=> !suspended)
      else $error("Suspend not left");
   chk_mask_read_hiz: assert property (@(posedge clk) disable iff (!rst_b)
      dqm |-> ##3 dq_oe_b)
      else $error("Read mask did not float outputs");
   chk_wake_pause: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> !ready [*8])
      else $error("Ready before pause");
   chk_mode_latency: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_ok && is_mrs |=> read_latency3 == $past(cmd.addr[4]))
      else $error("Mode load ignored");
   chk_col_every_cycle: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_ok && is_rd |=> rd_pipe_q[0])
      else $error("Read command dropped");
endmodule // sdram_command_spacing

// file: rtl/sdram_spacing_pkg.sv
package sdram_spacing_pkg;
   // Cycle figures, in clock cycles
   localparam int unsigned CLOCK_SUSPEND_ENTRY_DELAY = 1;
   localparam int unsigned CLOCK_SUSPEND_EXIT_DELAY = 1;
   localparam int unsigned WRITE_MASK_LATENCY = 0;
   localparam int unsigned READ_MASK_HIZ_LATENCY = 2;
   localparam int unsigned WRITE_DATA_LATENCY = 0;
   localparam int unsigned PRECHARGE_TO_OUTPUT_HIZ_CL3 = 3;
   localparam int unsigned PRECHARGE_TO_OUTPUT_HIZ_CL2 = 2;
   localparam int unsigned MODE_LOAD_TO_COMMAND_GAP = 2;
   localparam int unsigned WRITE_DATA_TO_PRECHARGE_GAP = 2;
   localparam int unsigned WRITE_AUTOPRECHARGE_TO_ACTIVATE_GAP = 4;
   localparam int unsigned COLUMN_COMMAND_GAP = 1;
   // Power-up pause
   localparam int unsigned POWER_UP_PAUSE_US = 100;
   localparam int unsigned CLK_MHZ = 10;
   localparam int unsigned POWER_UP_CYCLES = POWER_UP_PAUSE_US * CLK_MHZ;
   localparam int unsigned WAKE_REFRESH_COUNT = 2;
   localparam int unsigned DATA_WIDTH = 16;
   localparam int unsigned ADDR_WIDTH = 13;
   localparam int unsigned BANK_WIDTH = 2;
   localparam int unsigned READ_LATENCY_MAX = 3;

   // Command code {cs_b, ras_b, cas_b, we_b}
   typedef enum logic [3:0] {
      CMD_INHIBIT = 4'h8,
      CMD_NOP = 4'h7,
      CMD_ACTIVATE = 4'h3,
      CMD_READ = 4'h5,
      CMD_WRITE = 4'h4,
      CMD_STOP = 4'h6,
      CMD_PRECHARGE = 4'h2,
      CMD_REFRESH = 4'h1,
      CMD_MODE_LOAD = 4'h0
   } cmd_t;

   typedef struct packed {
      logic cs_b;
      logic ras_b;
      logic cas_b;
      logic we_b;
      logic [BANK_WIDTH-1:0] bank;
      logic [ADDR_WIDTH-1:0] addr;
   } cmd_bus_t;

   typedef struct packed {
      logic valid;
      logic [BANK_WIDTH-1:0] bank;
      logic [ADDR_WIDTH-1:0] addr;
      logic [DATA_WIDTH-1:0] data;
   } write_beat_t;
endpackage

// file: tb/sdram_command_spacing_tb_top.sv
`timescale 1ns/1ps
module sdram_command_spacing_tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cke, dqm, dq_oe_b, suspended, ready, read_latency3;
   logic [15:0] dq_in, read_data, dq_out, d;
   sdram_spacing_pkg::cmd_bus_t cmd;
   sdram_spacing_pkg::write_beat_t wr_beat;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   int k;
   logic [31:0] seed = 32'h875706F7;
   logic [15:0] exp_q[$];
   initial forever #50 clk = ~clk;
   sdram_ctl_model u_ctl (.clk(clk), .cke(cke), .cmd(cmd), .dqm(dqm),
      .dq_in(dq_in));
   sdram_command_spacing #(.POWER_UP_CYCLES(10)) u_dut (.clk(clk),
      .rst_b(rst_b), .cke(cke), .cmd(cmd), .dqm(dqm), .dq_in(dq_in),
      .read_data(read_data), .wr_beat(wr_beat), .dq_out(dq_out),
      .dq_oe_b(dq_oe_b), .suspended(suspended), .ready(ready),
      .read_latency3(read_latency3));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Every beat must have a note; a spurious one counts as a mismatch
   always @(posedge clk) begin
      #2;
      cyc++;
      if (wr_beat.valid === 1'b1) begin
         if (exp_q.size() == 0) check(1'b1, 1'b0);
         else check(wr_beat.data, exp_q.pop_front());
      end
      if (cyc > 3000) begin
         fails++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      read_data = xs();
      repeat (12) @(posedge clk);
      #1;
      rst_b = 1'b1;
      check({wr_beat.valid, dq_oe_b, suspended, read_latency3}, 4'h5);
      check(ready, 1'b0);
      // Write during the pause is refused: no note
      u_ctl.issue(sdram_spacing_pkg::CMD_WRITE, 13'h0000, 16'hA5A5, 1'b0);
      u_ctl.gap(10);
      repeat (2) u_ctl.issue(sdram_spacing_pkg::CMD_REFRESH, 13'(xs()),
         16'(xs()), 1'b0);
      for (n = 0; n < 8 && ready !== 1'b1; n++) u_ctl.gap(1);
      check(ready, 1'b1);
      $display("test wake done");
      for (n = 0; n < 2; n++) begin
         u_ctl.issue(sdram_spacing_pkg::CMD_MODE_LOAD, 13'h0020 | (n << 4),
            16'(xs()), 1'b0);
         u_ctl.gap(2);
         check(read_latency3, n[0]);
      end
      $display("test mode done");
      // Back-to-back writes with random masks
      for (n = 0; n < 8; n++) begin
         d = xs();
         if (d[0] == 1'b0) exp_q.push_back(d);
         u_ctl.issue(sdram_spacing_pkg::CMD_WRITE, 13'h0000, d, d[0]);
      end
      u_ctl.gap(2);
      u_ctl.issue(sdram_spacing_pkg::CMD_PRECHARGE, 13'(xs()), 16'(xs()),
         1'b0);
      u_ctl.gap(1);
      check(exp_q.size(), 0);
      $display("test writes done");
      u_ctl.set_cke(1'b0);
      u_ctl.issue(sdram_spacing_pkg::CMD_WRITE, 13'h0000, 16'h5A5A, 1'b0);
      u_ctl.gap(1);
      check(suspended, 1'b1);
      u_ctl.set_cke(1'b1);
      u_ctl.gap(2);
      check({suspended, exp_q.size() == 0}, 2'h1);
      $display("test suspend done");
      // Reads at latency 3, then 2; banks are idle before each mode load
      for (k = 1; k >= 0; k--) begin
         u_ctl.issue(sdram_spacing_pkg::CMD_MODE_LOAD, 13'h0020 | 13'(k << 4),
            16'(xs()), 1'b0);
         u_ctl.gap(2);
         read_data = 16'(xs());
         u_ctl.issue(sdram_spacing_pkg::CMD_ACTIVATE, 13'(xs()), 16'(xs()),
            1'b0);
         u_ctl.gap(2);
         u_ctl.issue(sdram_spacing_pkg::CMD_READ, 13'(xs()), 16'(xs()), 1'b0);
         for (n = 0; n < 6 && dq_oe_b !== 1'b0; n++) u_ctl.gap(1);
         check({dq_oe_b, dq_out}, {1'b0, read_data});
         // One masked cycle floats exactly one word, two edges on
         u_ctl.issue(sdram_spacing_pkg::CMD_NOP, 13'(xs()), 16'(xs()), 1'b1);
         u_ctl.gap(3);
         check(dq_oe_b, 1'b1);
         u_ctl.gap(1);
         check(dq_oe_b, 1'b0);
         u_ctl.issue(sdram_spacing_pkg::CMD_PRECHARGE, 13'(xs()), 16'(xs()),
            1'b0);
         for (n = 0; n < 6 && dq_oe_b !== 1'b1; n++) u_ctl.gap(1);
         check(n, (k != 0 ? sdram_spacing_pkg::PRECHARGE_TO_OUTPUT_HIZ_CL3
            : sdram_spacing_pkg::PRECHARGE_TO_OUTPUT_HIZ_CL2) + 1);
      end
      $display("test read done");
      end_of_test();
   end
endmodule // sdram_command_spacing_tb_top

// file: tb/sdram_ctl_model.sv
`timescale 1ns/1ps
// Controller side: one command per call, held across one sampling edge
module sdram_ctl_model (
   input wire logic clk,
   output logic cke,
   output sdram_spacing_pkg::cmd_bus_t cmd,
   output logic dqm,
   output logic [15:0] dq_in
);
   initial begin
      cke = 1'b1;
      dqm = 1'b0;
      dq_in = 16'h0000;
      cmd = {sdram_spacing_pkg::CMD_NOP, 2'h0, 13'h0000};
   end
   task automatic issue(input sdram_spacing_pkg::cmd_t c,
                        input logic [12:0] a, input logic [15:0] d,
                        input logic m);
      @(posedge clk);
      #1;
      cmd = {c, 2'h1, a};
      dqm = m;
      // Data travels with the write; otherwise the line toggles
      dq_in = (c == sdram_spacing_pkg::CMD_WRITE) ? d : ~dq_in;
   endtask
   // NOP gaps keep the controller-side spacing
   task automatic gap(input int n);
      repeat (n) issue(sdram_spacing_pkg::CMD_NOP, ~cmd.addr, ~dq_in, 1'b0);
   endtask
   task automatic set_cke(input logic v);
      @(posedge clk);
      #1;
      cke = v;
   endtask
endmodule // sdram_ctl_model
